// ===== rtl/lpc_irq_consts.svh
// Purpose: offsets, field positions, reset values and counts of the host interrupt block
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   definitions only
`ifndef LPC_IRQ_CONSTS_SVH
`define LPC_IRQ_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_ENABLE      8'h00
`define OFS_SELECT      8'h04
`define OFS_CONTROL     8'h08
`define OFS_OUTDATA     8'h0C
`define OFS_FLAGS       8'h10
`define OFS_IRQ_STATUS  8'h14
`define OFS_IRQ_MASK    8'h18

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_EN6         0
`define BIT_EN9         1
`define BIT_EN10        2
`define BIT_SEL_CH3_STATUS_REGISTER    7
`define BIT_DIRECT      0
`define BIT_SWRESET     1
`define BIT_OBF         0
`define BIT_CH3_HW      1
`define EV_OBF_CLEARED  0
`define EV_LPC_RESET    1
`define EV_SERIRQ_DONE  2
`define EV_WIDTH        3

// ****************************************************************
// reset values
// ****************************************************************
`define RST_ENABLE      3'h0
`define RST_SELECT      8'h00
`define RST_MASK        3'h0

// ****************************************************************
// serial interrupt frame layout
// ****************************************************************
`define SLOT_INT11      4'hB
`define SLOT_INT10      4'hA
`define SLOT_INT9       4'h9
`define SLOT_INT6       4'h6
`define SLOT_SYSMGMT    4'h2
`define SLOT_INT12      4'hC
`define SLOT_INT1       4'h1
`define START_MIN_LOWS  4
`define SLOT_COUNT      16

`endif

// ===== rtl/lpc_irq_pkg.sv
// Purpose: types shared by the host interrupt block and its bench
// Assumes: constants live in lpc_irq_consts.svh
// Notes:   request order matches the polarity select bits 6 down to 0
package lpc_irq_pkg;

  // ****************************************************************
  // host request set, msb first as in the select register
  // ****************************************************************
  typedef struct packed {
    logic int11;
    logic int10;
    logic int9;
    logic int6;
    logic sysmgmt;
    logic int12;
    logic int1;
  } host_req_t;

  // ****************************************************************
  // open-drain serial interrupt pin, driver side
  // ****************************************************************
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  typedef enum logic [2:0] {
    SER_IDLE,
    SER_START_RECOV,
    SER_START_TURN,
    SER_SAMPLE,
    SER_RECOV,
    SER_TURN
  } ser_state_t;

endpackage

// ===== rtl/lpc_host_irq_enable_select.sv
// Purpose: channel 2 host interrupt enables, select register and serial interrupt driver
// Assumes: lclk and serirq come from the host and are sampled by pclk
// Notes:   continuous serial interrupt mode only; the device never starts a cycle
//
// Summary of operation
// - the int10 enable (bit 2, reset 0) lets a data write that sets the output full flag raise int10.
// - with direct mode selected a set int10 enable raises int10 by itself, ignoring the flag.
// - the int10 enable clears on a write of 0 and, in flag mode, when the output full flag clears.
// - the int10 enable becomes 1 only on a write of 1 after software has read it as 0.
// - an lpc hardware or software reset clears the int10, int9 and int6 enables.
// - the int9 enable (bit 1, reset 0) gates int9 on the full flag in flag mode, drives it in direct.
// - the int9 enable becomes 1 only on a write of 1 after it was read as 0.
// - the int6 enable (bit 0, reset 0) gates int6 on the full flag in flag mode, drives it in direct.
// - the int6 enable becomes 1 only on a write of 1 after it was read as 0.
// - select bit 7 at 0 makes ch3 status bits 7..4 hardware bits; at 1 only with two-way mode.
// - select bits 6..0 set the polarity of int11, int10, int9, int6, sysmgmt, int12 and int1.
// - with polarity 0 the line floats for a clear request and is driven 0 for a set one.
// - with polarity 1 the line is driven 0 for a clear request and floats for a set one.
//
// Added by the designer: the APB slave port and the address map.
`include "lpc_irq_consts.svh"

module lpc_host_irq_enable_select
  import lpc_irq_pkg::*;
#(
  parameter int SLOTS = `SLOT_COUNT
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // host side of channel 2 and other request sources
  input  wire logic        ch2_host_read,
  input  wire logic        two_way_register_enable,
  input  wire logic        host_request_11,
  input  wire logic        host_request_12,
  input  wire logic        host_request_1,
  input  wire logic        sysmgmt_request,
  output logic      [7:0]  ch2_output_data_reg,
  output logic             ch3_status_hw_mode,
  // lpc pins
  input  wire logic        lreset_n,
  input  wire logic        lclk,
  input  wire logic        serirq_in,
  output logic             serirq_out,
  output logic             serirq_oe,
  // interrupt to the slave cpu
  output logic             irq
);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic [2:0]  enables;
  logic [2:0]  armed;
  logic [7:0]  host_interface_select;
  logic        direct_request_select;
  logic        ch2_outbuf_full_flag;
  logic [`EV_WIDTH-1:0] irq_status;
  logic [`EV_WIDTH-1:0] irq_mask;
  wire setup      = psel && !penable;
  wire access     = psel && penable;
  wire wr         = access && pwrite;
  wire rd         = access && !pwrite;
  wire hit_enable = paddr == `OFS_ENABLE;
  wire hit_select = paddr == `OFS_SELECT;
  wire hit_ctrl   = paddr == `OFS_CONTROL;
  wire hit_data   = paddr == `OFS_OUTDATA;
  wire hit_flags  = paddr == `OFS_FLAGS;
  wire hit_status = paddr == `OFS_IRQ_STATUS;
  wire hit_mask   = paddr == `OFS_IRQ_MASK;
  wire mapped     = hit_enable | hit_select | hit_ctrl | hit_data | hit_flags
                  | hit_status | hit_mask;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // the select register is write-only, so it reads back as zero
  wire [31:0] read_mux =
      hit_enable ? {29'h0, enables}
    : hit_ctrl   ? {31'h0, direct_request_select}
    : hit_data   ? {24'h0, ch2_output_data_reg}
    : hit_flags  ? {30'h0, ch3_status_hw_mode, ch2_outbuf_full_flag}
    : hit_status ? {29'h0, irq_status}
    : hit_mask   ? {29'h0, irq_mask}
    : 32'h0;
  // ****************************************************************
  // lpc reset pin synchroniser
  // ****************************************************************
  logic [1:0] lreset_sync;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lreset_sync <= 2'h0;
    else
      lreset_sync <= {lreset_sync[0], lreset_n};
  end

  wire sw_reset  = wr && hit_ctrl && pwdata[`BIT_SWRESET];
  wire lpc_reset = !lreset_sync[1] || sw_reset;
  // ****************************************************************
  // output buffer full flag and data
  // ****************************************************************
  wire odr_write  = wr && hit_data;
  wire obf_clear  = ch2_host_read && ch2_outbuf_full_flag && !odr_write;
  // a data write in the same cycle as a host read keeps the flag set
  wire next_obf = odr_write ? 1'b1 : (ch2_host_read || lpc_reset) ? 1'b0
                : ch2_outbuf_full_flag;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch2_outbuf_full_flag <= 1'b0;
      ch2_output_data_reg  <= 8'h00;
    end
    else
    begin
      ch2_outbuf_full_flag <= next_obf;
      if (odr_write)
        ch2_output_data_reg <= pwdata[7:0];
    end
  end
  // ****************************************************************
  // channel 2 enable bits
  // ****************************************************************
  wire read_enables = rd && hit_enable;
  wire wr_enables   = wr && hit_enable;
  wire flag_drop    = !direct_request_select && obf_clear;
  logic [2:0] next_enables;
  logic [2:0] next_armed;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_en
      // set only after a read returned 0; set wins over a flag clear
      wire set_bit = wr_enables && pwdata[g] && armed[g];
      wire clr_bit = (wr_enables && !pwdata[g]) || flag_drop;
      assign next_enables[g] = lpc_reset ? 1'b0
                             : set_bit   ? 1'b1
                             : clr_bit   ? 1'b0
                             : enables[g];
      // any write consumes the arming read
      assign next_armed[g] = read_enables ? !prdata[g] : wr_enables ? 1'b0 : armed[g];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enables <= `RST_ENABLE;
      armed   <= 3'h0;
    end
    else
    begin
      enables <= next_enables;
      armed   <= next_armed;
    end
  end
  // ****************************************************************
  // select and control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_interface_select <= `RST_SELECT;
      direct_request_select <= 1'b0;
    end
    else
    begin
      if (wr && hit_select)
        host_interface_select <= pwdata[7:0];
      if (wr && hit_ctrl)
        direct_request_select <= pwdata[`BIT_DIRECT];
    end
  end

  assign ch3_status_hw_mode = !host_interface_select[`BIT_SEL_CH3_STATUS_REGISTER]
                            || two_way_register_enable;
  // ****************************************************************
  // host request levels
  // ****************************************************************
  wire gate = direct_request_select || ch2_outbuf_full_flag;
  host_req_t req;
  assign req.int11   = host_request_11;
  assign req.int10   = enables[`BIT_EN10] && gate;
  assign req.int9    = enables[`BIT_EN9] && gate;
  assign req.int6    = enables[`BIT_EN6] && gate;
  assign req.sysmgmt = sysmgmt_request;
  assign req.int12   = host_request_12;
  assign req.int1    = host_request_1;

  // polarity 1 inverts: drive low while clear, float while set
  wire [6:0] pull_low = req ^ host_interface_select[6:0];
  wire [6:0][3:0] slot_of = {`SLOT_INT11, `SLOT_INT10, `SLOT_INT9, `SLOT_INT6,
                             `SLOT_SYSMGMT, `SLOT_INT12, `SLOT_INT1};
  // ****************************************************************
  // link clock and serial line sampling
  // ****************************************************************
  logic [1:0] lclk_sync;
  logic [1:0] ser_sync;
  logic       lclk_prev;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lclk_sync <= 2'h0;
      ser_sync  <= 2'h3;
      lclk_prev <= 1'b0;
    end
    else
    begin
      lclk_sync <= {lclk_sync[0], lclk};
      ser_sync  <= {ser_sync[0], serirq_in};
      lclk_prev <= lclk_sync[1];
    end
  end

  wire lclk_rise = lclk_sync[1] && !lclk_prev;
  wire line      = ser_sync[1];
  // ****************************************************************
  // serial interrupt frame tracker
  // ****************************************************************
  ser_state_t state;
  ser_state_t next_state;
  logic [3:0] low_count;
  logic [3:0] slot;
  logic [6:0] drove;
  logic [3:0] next_low_count;
  logic [3:0] next_slot;
  wire        last_slot = slot == 4'(SLOTS - 1);
  always_comb
  begin
    next_state     = state;
    next_low_count = low_count;
    next_slot      = slot;
    case (state)
      SER_IDLE:
      begin
        // a short low is a stop frame or noise; the first high is the host's recovery
        next_low_count = line ? 4'h0 : low_count + {3'h0, low_count != 4'hF};
        if (line && low_count >= 4'(`START_MIN_LOWS))
          next_state = SER_START_RECOV;
      end
      SER_START_RECOV: next_state = SER_START_TURN;
      SER_START_TURN:
      begin
        next_state = SER_SAMPLE;
        next_slot  = 4'h0;
      end
      SER_SAMPLE: next_state = SER_RECOV;
      SER_RECOV:  next_state = SER_TURN;
      SER_TURN:
      begin
        next_state = last_slot ? SER_IDLE : SER_SAMPLE;
        next_slot  = last_slot ? 4'h0 : slot + 4'h1;
      end
      default: next_state = SER_IDLE;
    endcase
  end

  // drive decision per request, each only in its own slot
  logic [6:0] drive_now;
  generate
    for (g = 0; g < 7; g++)
    begin : g_slot
      assign drive_now[g] = pull_low[g] && slot_of[g] == next_slot;
    end
  endgenerate
  wire in_sample = next_state == SER_SAMPLE;
  wire in_recov  = next_state == SER_RECOV;
  wire cycle_end = lclk_rise && state == SER_TURN && last_slot;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= SER_IDLE;
      low_count  <= 4'h0;
      slot       <= 4'h0;
      drove      <= 7'h0;
      serirq_out <= 1'b1;
      serirq_oe  <= 1'b0;
    end
    else if (lclk_rise)
    begin
      state     <= next_state;
      low_count <= next_low_count;
      slot      <= next_slot;
      // sample phase pulls low, recovery drives high once, else float
      drove      <= in_sample ? drive_now : 7'h0;
      serirq_out <= !in_sample;
      serirq_oe  <= (in_sample && |drive_now) || (in_recov && |drove);
    end
  end
  // ****************************************************************
  // slave interrupt: sticky status, read clears, set wins
  // ****************************************************************
  logic [`EV_WIDTH-1:0] events;
  assign events[`EV_OBF_CLEARED] = obf_clear;
  assign events[`EV_LPC_RESET]   = lpc_reset;
  assign events[`EV_SERIRQ_DONE] = cycle_end;
  wire status_read = rd && hit_status;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= '0;
      irq_mask   <= `RST_MASK;
      irq        <= 1'b0;
      prdata     <= 32'h0;
    end
    else
    begin
      // clear only what the read returned, so an event during its setup cycle survives
      irq_status <= events | (irq_status & ~(prdata[`EV_WIDTH-1:0] & {`EV_WIDTH{status_read}}));
      if (wr && hit_mask)
        irq_mask <= pwdata[`EV_WIDTH-1:0];
      irq <= |(irq_status & irq_mask);
      if (setup && !pwrite)
        prdata <= read_mux;
    end
  end

endmodule

// ===== tb/lpc_irq_sva.sv
// Purpose: port checks of the host interrupt block
// Assumes: bound to the top module, one clock domain
// Notes:   may tracks which enable bits software could have set
`include "lpc_irq_consts.svh"
module lpc_irq_sva
  import lpc_irq_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // pins
  input wire logic        two_way_register_enable,
  input wire logic        ch3_status_hw_mode,
  input wire logic        lreset_n,
  input wire logic        serirq_out,
  input wire logic        serirq_oe
);
  logic       acc;
  logic       rd_en;
  logic [2:0] may;
  logic [2:0] armed;
  logic       sel7;
  logic [5:0] oe_cnt;
  assign acc = psel && penable && pready;
  assign rd_en = acc && !pwrite && paddr == `OFS_ENABLE;
  // bits only shrink outside software writes, so may is an upper bound
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      may   <= 3'h0;
      armed <= 3'h0;
      sel7  <= 1'b0;
    end
    else if (acc && paddr == `OFS_ENABLE)
    begin
      may   <= pwrite ? pwdata[2:0] & (may | armed) : prdata[2:0];
      armed <= pwrite ? 3'h0 : ~prdata[2:0];
    end
    else if (acc && pwrite && paddr == `OFS_SELECT)
      sel7 <= pwdata[`BIT_SEL_CH3_STATUS_REGISTER];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      oe_cnt <= 6'h0;
    else
      oe_cnt <= serirq_oe ? oe_cnt + 6'h1 : 6'h0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_en_only_armed: assert property (
    rd_en |-> (prdata[2:0] & ~may) == 3'h0) else $error("enable set without arming");
  chk_en_upper_zero: assert property (
    rd_en |-> prdata[31:3] == 29'h0) else $error("enable upper bits set");
  chk_lpc_rst_clear: assert property (
    rd_en && $past(lreset_n, 4) == 1'b0 && $past(lreset_n, 5) == 1'b0
    |-> prdata[2:0] == 3'h0) else $error("enables survive lpc reset");
  chk_ch3_hw_mode: assert property (
    ch3_status_hw_mode == (!sel7 || two_way_register_enable)) else $error("ch3 mode wrong");
  chk_sel_write_only: assert property (
    acc && !pwrite && paddr == `OFS_SELECT |-> prdata == 32'h0) else $error("select readable");
  chk_drive_low_first: assert property (
    $rose(serirq_oe) |-> (serirq_oe && !serirq_out) [*8]) else $error("drive not low");
  chk_release_high: assert property (
    $fell(serirq_oe) |-> $past(serirq_out)) else $error("released while low");
  chk_drive_bounded: assert property (
    oe_cnt < 6'h30) else $error("line driven beyond one slot");
endmodule
bind lpc_host_irq_enable_select lpc_irq_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .two_way_register_enable, .ch3_status_hw_mode,
  .lreset_n, .serirq_out, .serirq_oe);

// ===== tb/lpc_host_model.sv
// Purpose: host end of the serial interrupt line
// Assumes: pull-up on the line, continuous mode
// Notes:   lclk stands still between cycles
module lpc_host_model
(
  // link
  output logic        lclk,
  output logic        serirq_in,
  input  wire logic   serirq_out,
  input  wire logic   serirq_oe,
  // one bit per slot, 1 = line seen low
  output logic [15:0] slot_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_low;
  // a released line floats up to 1
  assign serirq_in = host_low ? 1'b0 : (serirq_oe ? serirq_out : 1'b1);
  initial
  begin
    lclk     = 1'b0;
    host_low = 1'b0;
    slot_low = 16'h0;
  end
  // line read late in the high half, after the device has updated
  task automatic tick(output logic seen);
    #80 lclk = 1'b1;
    #70 seen = serirq_in;
    #10 lclk = 1'b0;
  endtask
  task automatic run_cycle();
    logic v;
    host_low = 1'b1;
    repeat (4) tick(v);
    host_low = 1'b0;
    repeat (2) tick(v);
    for (int s = 0; s < 16; s++)
    begin
      tick(v);
      slot_low[s] = ~v;
      repeat (2) tick(v);
    end
    // short stop frame, must not be taken as a start
    host_low = 1'b1;
    repeat (2) tick(v);
    host_low = 1'b0;
    repeat (2) tick(v);
  endtask
endmodule

// ===== tb/lpc_host_irq_enable_select_tb_top.sv
// Purpose: self-checking bench of the host interrupt block
// Assumes: apb master here, host model on the serial line
// Notes:   lpc reset stays visible two cycles after presetn release
`include "lpc_irq_consts.svh"
module lpc_host_irq_enable_select_tb_top
  import lpc_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] pre;
    logic [2:0] pdat;
    logic [2:0] wdat;
    logic [2:0] exp;
  } en_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, ch2_output_data_reg;
  logic [31:0] pwdata, prdata, q;
  logic        ch2_host_read, two_way_register_enable, ch3_status_hw_mode, irq;
  logic        host_request_11, host_request_12, host_request_1, sysmgmt_request;
  logic        lreset_n, lclk, serirq_in, serirq_out, serirq_oe;
  logic [15:0] slot_low;
  int          n_mismatch, checked;
  en_row_t     rows [6] = '{'{2'h2, 3'h0, 3'h7, 3'h0}, '{2'h1, 3'h0, 3'h5, 3'h5},
                            '{2'h2, 3'h5, 3'h7, 3'h5}, '{2'h1, 3'h0, 3'h7, 3'h7},
                            '{2'h0, 3'h0, 3'h2, 3'h2}, '{2'h1, 3'h0, 3'h0, 3'h0}};
  logic [6:0]  pols [3] = '{7'h00, 7'h7F, 7'h2A};
  lpc_host_irq_enable_select dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ch2_host_read, .two_way_register_enable,
    .host_request_11, .host_request_12, .host_request_1, .sysmgmt_request,
    .ch2_output_data_reg, .ch3_status_hw_mode, .lreset_n, .lclk, .serirq_in,
    .serirq_out, .serirq_oe, .irq);
  lpc_host_model host_u (.lclk, .serirq_in, .serirq_out, .serirq_oe, .slot_low);
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ********
  // tasks
  // ********
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic host_read();
    ch2_host_read <= 1'b1;
    @(posedge pclk);
    ch2_host_read <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] exp_slots(host_req_t r, logic [6:0] pol);
    logic [15:0] s;
    host_req_t   x;
    x = host_req_t'(r ^ pol);
    s = 16'h0;
    s[`SLOT_INT11] = x.int11;
    s[`SLOT_INT10] = x.int10;
    s[`SLOT_INT9] = x.int9;
    s[`SLOT_INT6] = x.int6;
    s[`SLOT_SYSMGMT] = x.sysmgmt;
    s[`SLOT_INT12] = x.int12;
    s[`SLOT_INT1] = x.int1;
    return s;
  endfunction
  task automatic serial(input logic [6:0] r, input logic [6:0] pol);
    wr(`OFS_SELECT, {25'h0, pol});
    host_u.run_cycle();
    @(posedge pclk);
    check({16'h0, slot_low}, {16'h0, exp_slots(host_req_t'(r), pol)});
  endtask
  // ********
  // sequence
  // ********
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ch2_host_read} = '0;
    {two_way_register_enable, host_request_11, host_request_12} = '0;
    {host_request_1, sysmgmt_request} = '0;
    lreset_n = 1'b1;
    n_mismatch = 0;
    checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`OFS_ENABLE);
    check(q, 32'h0);
    rd(`OFS_SELECT);
    check(q, 32'h0);
    rd(8'h40);
    check({e, q[30:0]}, 32'h80000000);
    $display("reset test done");
    foreach (rows[i])
    begin
      if (rows[i].pre == 2'h1)
        rd(`OFS_ENABLE);
      if (rows[i].pre == 2'h2)
        wr(`OFS_ENABLE, {29'h0, rows[i].pdat});
      wr(`OFS_ENABLE, {29'h0, rows[i].wdat});
      rd(`OFS_ENABLE);
      check(q, {29'h0, rows[i].exp});
    end
    $display("enable table done");
    for (int k = 0; k < 4; k++)
    begin
      wr(`OFS_SELECT, {24'h0, k[1], 7'h0});
      two_way_register_enable <= k[0];
      @(posedge pclk);
      check({31'h0, ch3_status_hw_mode}, {31'h0, !k[1] || k[0]});
    end
    $display("select test done");
    wr(`OFS_CONTROL, 32'h1);
    rd(`OFS_ENABLE);
    wr(`OFS_ENABLE, 32'h4);
    host_request_11 <= 1'b1;
    host_request_1 <= 1'b1;
    foreach (pols[i])
      serial(7'h61, pols[i]);
    wr(`OFS_OUTDATA, 32'hA5);
    check({24'h0, ch2_output_data_reg}, 32'hA5);
    host_read();
    rd(`OFS_ENABLE);
    check(q, 32'h4);
    $display("direct mode test done");
    wr(`OFS_CONTROL, 32'h0);
    rd(`OFS_ENABLE);
    wr(`OFS_ENABLE, 32'h7);
    {host_request_11, host_request_1} <= 2'h0;
    {host_request_12, sysmgmt_request} <= 2'h3;
    serial(7'h06, 7'h00);
    wr(`OFS_OUTDATA, 32'h3C);
    serial(7'h3E, 7'h00);
    host_read();
    rd(`OFS_ENABLE);
    check(q, 32'h0);
    rd(`OFS_FLAGS);
    check(q, 32'h2);
    $display("flag mode test done");
    wr(`OFS_IRQ_MASK, 32'h2);
    rd(`OFS_IRQ_STATUS);
    check(q, 32'h7);
    rd(`OFS_ENABLE);
    wr(`OFS_ENABLE, 32'h7);
    wr(`OFS_CONTROL, 32'h2);
    @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    rd(`OFS_ENABLE);
    check(q, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h0);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h2);
    @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    rd(`OFS_IRQ_STATUS);
    check(q, 32'h2);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    rd(`OFS_ENABLE);
    wr(`OFS_ENABLE, 32'h7);
    lreset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(`OFS_ENABLE);
    check(q, 32'h0);
    lreset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    $display("interrupt and lpc reset test done");
    test_done();
  end
endmodule
